/* verilog/jmd_defines.svh */
`ifndef JMD_DEFINES_SVH
`define JMD_DEFINES_SVH

// register indices, byte address is four times the index
`define JMD_IDX_PWR1 8'h14
`define JMD_IDX_PWR3 8'h15
`define JMD_IDX_IRQ_POL 8'h19
`define JMD_IDX_IRQ_EN 8'h1a
`define JMD_IDX_PIN_FN 8'h1b
`define JMD_IDX_OUT_CTL 8'h2d
`define JMD_IDX_BIAS_CMP 8'h33
`define JMD_IDX_CLK_SRC 8'h34
`define JMD_IDX_STATUS 8'h3f

// reset value of every writable register
`define JMD_REG_RESET 9'h000

// field positions
`define JMD_MIC_BIAS_BIT 5
`define JMD_HP_L_BIT 8
`define JMD_HP_R_BIT 7
`define JMD_SPK_L_BIT 6
`define JMD_SPK_R_BIT 5
`define JMD_CUR_IRQ_BIT 1
`define JMD_SW_IRQ_BIT 2
`define JMD_IRQ_CFG_HI 8
`define JMD_IRQ_CFG_LO 7
`define JMD_IRQ_PIN_HI 4
`define JMD_IRQ_PIN_LO 3
`define JMD_JACK_CFG_HI 2
`define JMD_JACK_CFG_LO 0
`define JMD_HPSW_EN_BIT 6
`define JMD_HPSW_POL_BIT 5
`define JMD_VSEL_BIT 8
`define JMD_THR_HI 3
`define JMD_THR_LO 1
`define JMD_CMP_EN_BIT 0
`define JMD_TOCLK_SEL_BIT 5

// field codes
`define JMD_JACK_INPUT 3'h0
`define JMD_JACK_PULLUP 3'h1
`define JMD_JACK_PULLDN 3'h2
`define JMD_IRQ_PIN_OUT 2'h1
`define JMD_IRQ_ACT_HIGH 2'h2
`define JMD_IRQ_ACT_LOW 2'h3

// debounce timeout in edges of the selected timeout clock
`define JMD_DBNC_TICKS 10'h3ff

`endif

/* verilog/jmd_pkg.sv */
package jmd_pkg;

  // register selected by a bus address
  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_PWR1,
    SEL_PWR3,
    SEL_IRQ_POL,
    SEL_IRQ_EN,
    SEL_PIN_FN,
    SEL_OUT_CTL,
    SEL_BIAS_CMP,
    SEL_CLK_SRC,
    SEL_STATUS
  } jmd_sel_t;

  // debounce state
  typedef struct packed {
    logic tick_prev;
    logic [9:0] cnt;
    logic level;
  } jmd_dbnc_st_t;

  // one latched interrupt source
  typedef struct packed {
    logic flag;
  } jmd_latch_st_t;

  // whole state of the top module
  typedef struct packed {
    logic [8:0] pwr1;
    logic [8:0] pwr3;
    logic [8:0] irq_pol;
    logic [8:0] irq_en;
    logic [8:0] pin_fn;
    logic [8:0] out_ctl;
    logic [8:0] bias_cmp;
    logic [8:0] clk_src;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_o;
    logic irq_oe;
    logic pull_up;
    logic pull_dn;
    logic hp_l;
    logic hp_r;
    logic spk_l;
    logic spk_r;
    logic mic_bias_power;
    logic vsel;
    logic [2:0] thr;
    logic cmp_en;
  } jmd_top_st_t;

endpackage

/* verilog/jmd_dbnc_if.sv */
`timescale 1ns/1ns
interface jmd_dbnc_if;
  logic sense_raw;
  logic tick_sel;
  logic mclk_in;
  logic vclk_in;
  logic level;
  modport ctrl (output sense_raw, output tick_sel, output mclk_in, output vclk_in, input level);
  modport dbnc (input sense_raw, input tick_sel, input mclk_in, input vclk_in, output level);
endinterface

/* verilog/jmd_debounce.sv */
`timescale 1ns/1ns
`include "jmd_defines.svh"
module jmd_debounce (
  input wire logic pclk,
  input wire logic presetn,
  jmd_dbnc_if.dbnc db
);
  jmd_pkg::jmd_dbnc_st_t s_q;
  jmd_pkg::jmd_dbnc_st_t s_d;
  logic tick_now;

  // selected timeout clock, sampled as a level
  assign tick_now = db.tick_sel ? db.vclk_in : db.mclk_in;

  // count timeout edges while the pin differs from the accepted level
  always_comb
  begin
    s_d = s_q;
    s_d.tick_prev = tick_now;
    if (db.sense_raw == s_q.level)
    begin
      s_d.cnt = 10'h000;
    end
    else if (tick_now && !s_q.tick_prev)
    begin
      if (s_q.cnt == `JMD_DBNC_TICKS - 10'h001)
      begin
        s_d.level = db.sense_raw;
        s_d.cnt = 10'h000;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign db.level = s_q.level;
endmodule

/* verilog/jmd_irq_latch.sv */
`timescale 1ns/1ns
module jmd_irq_latch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic cond,
  output logic flag
);
  jmd_pkg::jmd_latch_st_t s_q;
  jmd_pkg::jmd_latch_st_t s_d;

  // sets on an enabled condition, holds, clears only while disabled
  always_comb
  begin
    s_d = s_q;
    if (!enable)
      s_d.flag = 1'b0;
    else if (cond)
      s_d.flag = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign flag = s_q.flag;
endmodule

/* verilog/jmd_jack_irq_top.sv */
// Operation
// - jack level, polarity choose headphone or speaker
// - clock select bit picks debounce timeout clock
// - jack pin codes connect internal pull resistors
// - jack detect raises selectable polarity interrupt
// - power bit switches microphone bias supply on
// - bias select bit zero gives 0.9 supply
// - threshold code bits set detection threshold
// - comparator enable bit turns comparator on
// - current polarity zero fires above threshold
// - current enable lets detection set interrupt
// - output config code 10 is active high
// - pin config code 01 makes interrupt output
// - interrupt latched until source enable cleared
// - interrupt can report jack switch state
// - switch enable bit turns on autonomous switching
// - jack pin code 000 is plain input
// - inserted plug reads high, removed reads low
`timescale 1ns/1ns
`include "jmd_defines.svh"
module jmd_jack_irq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic jack_sense_pin,
  input wire logic master_clock_input,
  input wire logic voice_port_clock,
  input wire logic bias_current_above,
  output logic irq_output_pin_o,
  output logic irq_output_pin_oe,
  output logic jack_pull_up_en,
  output logic jack_pull_down_en,
  output logic hp_left_en,
  output logic hp_right_en,
  output logic spk_left_en,
  output logic spk_right_en,
  output logic mic_bias_en,
  output logic bias_voltage_sel,
  output logic [2:0] current_threshold_code,
  output logic comparator_en
);

  jmd_pkg::jmd_top_st_t s_q;
  jmd_pkg::jmd_top_st_t s_d;

  // debounced jack level and latched interrupt flags
  logic jack_level;
  logic [1:0] irq_flag;
  logic [1:0] irq_enable;
  logic [1:0] irq_cond;
  logic cur_cond;
  logic sw_cond;
  logic jack_hp_sel;
  logic irq_any;

  // bus decode helpers
  logic setup_ph;
  logic access_ph;
  jmd_pkg::jmd_sel_t setup_sel;
  jmd_pkg::jmd_sel_t access_sel;

  // address to register decode, used for setup and access phases
  function automatic jmd_pkg::jmd_sel_t reg_sel(input logic [11:0] addr);
    jmd_pkg::jmd_sel_t r;
    r = jmd_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[9:2])
        `JMD_IDX_PWR1: r = jmd_pkg::SEL_PWR1;
        `JMD_IDX_PWR3: r = jmd_pkg::SEL_PWR3;
        `JMD_IDX_IRQ_POL: r = jmd_pkg::SEL_IRQ_POL;
        `JMD_IDX_IRQ_EN: r = jmd_pkg::SEL_IRQ_EN;
        `JMD_IDX_PIN_FN: r = jmd_pkg::SEL_PIN_FN;
        `JMD_IDX_OUT_CTL: r = jmd_pkg::SEL_OUT_CTL;
        `JMD_IDX_BIAS_CMP: r = jmd_pkg::SEL_BIAS_CMP;
        `JMD_IDX_CLK_SRC: r = jmd_pkg::SEL_CLK_SRC;
        `JMD_IDX_STATUS: r = jmd_pkg::SEL_STATUS;
        default: r = jmd_pkg::SEL_NONE;
      endcase
    end
    if (addr[11:10] != 2'h0)
      r = jmd_pkg::SEL_NONE;
    return r;
  endfunction

  // read value of one register
  function automatic logic [8:0] reg_value(
    input jmd_pkg::jmd_sel_t sel,
    input jmd_pkg::jmd_top_st_t st,
    input logic [4:0] status
  );
    logic [8:0] v;
    v = 9'h000;
    case (sel)
      jmd_pkg::SEL_PWR1: v = st.pwr1;
      jmd_pkg::SEL_PWR3: v = st.pwr3;
      jmd_pkg::SEL_IRQ_POL: v = st.irq_pol;
      jmd_pkg::SEL_IRQ_EN: v = st.irq_en;
      jmd_pkg::SEL_PIN_FN: v = st.pin_fn;
      jmd_pkg::SEL_OUT_CTL: v = st.out_ctl;
      jmd_pkg::SEL_BIAS_CMP: v = st.bias_cmp;
      jmd_pkg::SEL_CLK_SRC: v = st.clk_src;
      jmd_pkg::SEL_STATUS: v = {4'h0, status};
      default: v = 9'h000;
    endcase
    return v;
  endfunction

  // debounce of the jack sense pin
  jmd_dbnc_if dbnc_bus ();

  assign dbnc_bus.sense_raw = jack_sense_pin; // high on insertion
  assign dbnc_bus.tick_sel = s_q.clk_src[`JMD_TOCLK_SEL_BIT]; // 0 master, 1 voice port
  assign dbnc_bus.mclk_in = master_clock_input;
  assign dbnc_bus.vclk_in = voice_port_clock;
  assign jack_level = dbnc_bus.level;

  jmd_debounce u_dbnc (
    .pclk(pclk),
    .presetn(presetn),
    .db(dbnc_bus.dbnc)
  ); // switching and interrupt see only the debounced level

  // interrupt conditions
  // current detect: above threshold when polarity 0 below when 1
  assign cur_cond = s_q.bias_cmp[`JMD_CMP_EN_BIT] && s_q.pwr1[`JMD_MIC_BIAS_BIT]
    && (bias_current_above ^ s_q.irq_pol[`JMD_CUR_IRQ_BIT]);
  // jack switch state, insertion or removal by polarity
  assign sw_cond = jack_level ^ s_q.irq_pol[`JMD_SW_IRQ_BIT];

  assign irq_cond = {sw_cond, cur_cond};
  assign irq_enable = {s_q.irq_en[`JMD_SW_IRQ_BIT], s_q.irq_en[`JMD_CUR_IRQ_BIT]};

  // one latch per source, cleared by writing its enable to 0
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_src
      jmd_irq_latch u_latch (
        .pclk(pclk),
        .presetn(presetn),
        .enable(irq_enable[gi]),
        .cond(irq_cond[gi]),
        .flag(irq_flag[gi])
      );
    end
  endgenerate

  assign irq_any = |irq_flag;

  // headphone selected by debounced level and switch polarity
  assign jack_hp_sel = jack_level ^ s_q.out_ctl[`JMD_HPSW_POL_BIT];

  // bus phases
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && s_q.pready;
  assign setup_sel = reg_sel(paddr);
  assign access_sel = reg_sel(paddr);

  // next state of registers, bus answer and pin outputs
  always_comb
  begin
    s_d = s_q;

    // zero wait state answer prepared in the setup cycle
    s_d.pready = setup_ph;
    if (setup_ph)
    begin
      s_d.pslverr = (setup_sel == jmd_pkg::SEL_NONE);
      if (pwrite)
        s_d.prdata = 32'h0000_0000;
      else
        s_d.prdata = {23'h000000, reg_value(setup_sel, s_q,
          {irq_any, irq_flag[1], irq_flag[0], cur_cond, jack_level})};
    end
    else if (!psel)
    begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
    end

    // register write at the access edge
    if (access_ph && pwrite && !s_q.pslverr)
    begin
      case (access_sel)
        jmd_pkg::SEL_PWR1: s_d.pwr1 = pwdata[8:0];
        jmd_pkg::SEL_PWR3: s_d.pwr3 = pwdata[8:0];
        jmd_pkg::SEL_IRQ_POL: s_d.irq_pol = pwdata[8:0];
        jmd_pkg::SEL_IRQ_EN: s_d.irq_en = pwdata[8:0];
        jmd_pkg::SEL_PIN_FN: s_d.pin_fn = pwdata[8:0];
        jmd_pkg::SEL_OUT_CTL: s_d.out_ctl = pwdata[8:0];
        jmd_pkg::SEL_BIAS_CMP: s_d.bias_cmp = pwdata[8:0];
        jmd_pkg::SEL_CLK_SRC: s_d.clk_src = pwdata[8:0];
        default: s_d.pwr1 = s_q.pwr1;
      endcase
    end

    // output drivers gated by the jack switch, never enabled by it
    s_d.hp_l = s_q.pwr3[`JMD_HP_L_BIT]
      && (!s_q.out_ctl[`JMD_HPSW_EN_BIT] || jack_hp_sel);
    s_d.hp_r = s_q.pwr3[`JMD_HP_R_BIT]
      && (!s_q.out_ctl[`JMD_HPSW_EN_BIT] || jack_hp_sel);
    s_d.spk_l = s_q.pwr3[`JMD_SPK_L_BIT]
      && (!s_q.out_ctl[`JMD_HPSW_EN_BIT] || !jack_hp_sel);
    s_d.spk_r = s_q.pwr3[`JMD_SPK_R_BIT]
      && (!s_q.out_ctl[`JMD_HPSW_EN_BIT] || !jack_hp_sel);

    // microphone bias and comparator controls
    s_d.mic_bias_power = s_q.pwr1[`JMD_MIC_BIAS_BIT];
    s_d.vsel = s_q.bias_cmp[`JMD_VSEL_BIT]; // 0 gives 0.9 supply
    s_d.thr = s_q.bias_cmp[`JMD_THR_HI:`JMD_THR_LO]; // 001 is 410 uA
    s_d.cmp_en = s_q.bias_cmp[`JMD_CMP_EN_BIT];

    // jack pin pull resistors, code 000 plain input
    s_d.pull_up = (s_q.pin_fn[`JMD_JACK_CFG_HI:`JMD_JACK_CFG_LO] == `JMD_JACK_PULLUP);
    s_d.pull_dn = (s_q.pin_fn[`JMD_JACK_CFG_HI:`JMD_JACK_CFG_LO] == `JMD_JACK_PULLDN);
    if (s_q.pin_fn[`JMD_JACK_CFG_HI:`JMD_JACK_CFG_LO] == `JMD_JACK_INPUT)
    begin
      s_d.pull_up = 1'b0;
      s_d.pull_dn = 1'b0;
    end

    // interrupt pin drive
    s_d.irq_o = 1'b0;
    s_d.irq_oe = 1'b0;
    if (s_q.pin_fn[`JMD_IRQ_PIN_HI:`JMD_IRQ_PIN_LO] == `JMD_IRQ_PIN_OUT)
    begin
      case (s_q.pin_fn[`JMD_IRQ_CFG_HI:`JMD_IRQ_CFG_LO])
        `JMD_IRQ_ACT_HIGH:
        begin
          s_d.irq_o = irq_any;
          s_d.irq_oe = 1'b1;
        end
        `JMD_IRQ_ACT_LOW:
        begin
          s_d.irq_o = !irq_any;
          s_d.irq_oe = 1'b1;
        end
        default:
        begin
          s_d.irq_o = 1'b0; // open drain, pulls low while asserted
          s_d.irq_oe = irq_any;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.pwr1 <= `JMD_REG_RESET;
      s_q.pwr3 <= `JMD_REG_RESET;
      s_q.irq_pol <= `JMD_REG_RESET;
      s_q.irq_en <= `JMD_REG_RESET;
      s_q.pin_fn <= `JMD_REG_RESET;
      s_q.out_ctl <= `JMD_REG_RESET;
      s_q.bias_cmp <= `JMD_REG_RESET;
      s_q.clk_src <= `JMD_REG_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // all outputs straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq_output_pin_o = s_q.irq_o;
  assign irq_output_pin_oe = s_q.irq_oe;
  assign jack_pull_up_en = s_q.pull_up;
  assign jack_pull_down_en = s_q.pull_dn;
  assign hp_left_en = s_q.hp_l;
  assign hp_right_en = s_q.hp_r;
  assign spk_left_en = s_q.spk_l;
  assign spk_right_en = s_q.spk_r;
  assign mic_bias_en = s_q.mic_bias_power;
  assign bias_voltage_sel = s_q.vsel;
  assign current_threshold_code = s_q.thr;
  assign comparator_en = s_q.cmp_en;

endmodule

/* dv/jmd_jack_irq_assertions.sv */
`timescale 1ns/1ns
`include "jmd_defines.svh"
module jmd_jack_irq_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bias_current_above,
  input wire logic irq_output_pin_o,
  input wire logic irq_output_pin_oe,
  input wire logic jack_pull_up_en,
  input wire logic jack_pull_down_en,
  input wire logic hp_left_en,
  input wire logic hp_right_en,
  input wire logic spk_left_en,
  input wire logic spk_right_en,
  input wire logic mic_bias_en,
  input wire logic bias_voltage_sel,
  input wire logic [2:0] current_threshold_code,
  input wire logic comparator_en
);
  logic [8:0] pwr3_q, pol_q, en_q, pin_q, oc_q;
  logic acc, fire;
  logic [3:0] drv;
  // completed write and driver view
  assign acc = psel && penable && pwrite && pready && !pslverr;
  assign drv = {hp_left_en, hp_right_en, spk_left_en, spk_right_en};
  assign fire = en_q[1] && (bias_current_above ^ pol_q[1]) && mic_bias_en && comparator_en
    && pin_q[8:7] == 2'h2 && pin_q[4:3] == 2'h1;
  // shadow copies of pwr3, irq_pol, irq_en, pin_fn and out_ctl
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {pwr3_q, pol_q, en_q, pin_q, oc_q} <= '0;
    end
    else if (acc)
    begin
      if (paddr == {2'h0, `JMD_IDX_PWR3, 2'h0}) pwr3_q <= pwdata[8:0];
      if (paddr == {2'h0, `JMD_IDX_IRQ_POL, 2'h0}) pol_q <= pwdata[8:0];
      if (paddr == {2'h0, `JMD_IDX_IRQ_EN, 2'h0}) en_q <= pwdata[8:0];
      if (paddr == {2'h0, `JMD_IDX_PIN_FN, 2'h0}) pin_q <= pwdata[8:0];
      if (paddr == {2'h0, `JMD_IDX_OUT_CTL, 2'h0}) oc_q <= pwdata[8:0];
    end
  end
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  mic_bias_a:
    assert property (acc && paddr == {2'h0, `JMD_IDX_PWR1, 2'h0}
      |-> ##2 mic_bias_en == $past(pwdata[5], 2)) else $error("mic bias enable wrong");
  bias_fields_a:
    assert property (acc && paddr == {2'h0, `JMD_IDX_BIAS_CMP, 2'h0} |-> ##2
      {bias_voltage_sel, current_threshold_code, comparator_en}
      == {$past(pwdata[8], 2), $past(pwdata[3:0], 2)}) else $error("bias fields wrong");
  pull_code_a:
    assert property (jack_pull_up_en == ($past(pin_q[2:0]) == 3'h1)
      && jack_pull_down_en == ($past(pin_q[2:0]) == 3'h2)) else $error("pull control wrong");
  drv_gate_a:
    assert property ((drv & ~$past(pwr3_q[8:5])) == 4'h0) else $error("unpowered driver on");
  switch_off_a:
    assert property (!$past(oc_q[6]) |-> drv == $past(pwr3_q[8:5]))
      else $error("drivers switched while switch disabled");
  switch_excl_a:
    assert property ($past(oc_q[6]) && $past(pwr3_q[8:5]) == 4'hf |-> hp_left_en != spk_left_en)
      else $error("headphone and speaker not exclusive");
  irq_undriven_a:
    assert property ($past(pin_q[4:3]) != 2'h1 |-> !irq_output_pin_oe)
      else $error("irq pin driven without pin config");
  irq_fire_a:
    assert property (fire [*5] |-> irq_output_pin_oe && irq_output_pin_o)
      else $error("current irq not raised");
  irq_clear_a:
    assert property ((en_q[2:1] == 2'h0 && pin_q[8:7] == 2'h2 && pin_q[4:3] == 2'h1) [*4]
      |-> irq_output_pin_oe && !irq_output_pin_o) else $error("irq not cleared");
  // main scenarios reached
  cover property (fire [*5]);
  cover property ($rose(hp_left_en));
  cover property (pready && pslverr);
endmodule
bind jmd_jack_irq_top jmd_jack_irq_assertions chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .bias_current_above(bias_current_above),
  .irq_output_pin_o(irq_output_pin_o), .irq_output_pin_oe(irq_output_pin_oe),
  .jack_pull_up_en(jack_pull_up_en), .jack_pull_down_en(jack_pull_down_en),
  .hp_left_en(hp_left_en), .hp_right_en(hp_right_en), .spk_left_en(spk_left_en),
  .spk_right_en(spk_right_en), .mic_bias_en(mic_bias_en), .bias_voltage_sel(bias_voltage_sel),
  .current_threshold_code(current_threshold_code), .comparator_en(comparator_en));

/* dv/jmd_host_model.sv */
`timescale 1ns/1ns
module jmd_host_model (
  input wire logic pclk,
  input wire logic irq_o,
  input wire logic irq_oe,
  output logic irq_line,
  output int irq_count
);
  logic prev_q = 1'b1;
  int count_q = 0;
  // host pull-up: a released line reads high
  assign irq_line = irq_oe ? irq_o : 1'b1;
  assign irq_count = count_q;
  // count each rising edge of the host line, a new interrupt only in active high mode
  always @(posedge pclk)
  begin
    prev_q <= irq_line;
    if (irq_line && !prev_q) count_q <= count_q + 1;
  end
endmodule

/* dv/test_jack_and_mic_detect_irq.sv */
`timescale 1ns/1ns
`include "jmd_defines.svh"
module test_jack_and_mic_detect_irq;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, jack, mclk, vclk, above;
  logic irq_o, irq_oe, irq_line, pu, pd, hl, hr, sl, sr, mb, vs, ce, run_m, run_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] thr;
  logic [8:0] v;
  logic [32:0] expq[$];
  int miscompares, checks, seed, irq_count, base;
  logic [7:0] regs [8] = '{`JMD_IDX_PWR1, `JMD_IDX_PWR3, `JMD_IDX_IRQ_POL, `JMD_IDX_IRQ_EN,
    `JMD_IDX_PIN_FN, `JMD_IDX_OUT_CTL, `JMD_IDX_BIAS_CMP, `JMD_IDX_CLK_SRC};
  jmd_jack_irq_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .jack_sense_pin(jack), .master_clock_input(mclk),
    .voice_port_clock(vclk), .bias_current_above(above), .irq_output_pin_o(irq_o),
    .irq_output_pin_oe(irq_oe), .jack_pull_up_en(pu), .jack_pull_down_en(pd),
    .hp_left_en(hl), .hp_right_en(hr), .spk_left_en(sl), .spk_right_en(sr),
    .mic_bias_en(mb), .bias_voltage_sel(vs), .current_threshold_code(thr), .comparator_en(ce));
  jmd_host_model host (.pclk(pclk), .irq_o(irq_o), .irq_oe(irq_oe), .irq_line(irq_line),
    .irq_count(irq_count));
  // bus clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // timeout clocks run only while enabled
  always @(posedge pclk)
  begin
    if (run_m) mclk <= ~mclk;
    if (run_v) vclk <= ~vclk;
  end
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one bus transfer; the expected answer is queued for the monitor
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [8:0] d, input logic e);
    int i;
    expq.push_back({e, (w || e) ? 32'h0 : {23'h0, d}});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {23'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) miscompares++;
    if (i == 20) complete_run();
    @(posedge pclk);
  endtask
  // wait a bounded time for the driver enables
  task automatic wait_drv(input logic [3:0] e, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      if ({hl, hr, sl, sr} === e) break;
      @(posedge pclk);
    end
    check("drivers", {29'h0, hl, hr, sl, sr}, {29'h0, e});
    if (i == lim) complete_run();
  endtask
  // answer monitor takes the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1)
      check("answer", {pslverr, prdata}, expq.size() ? expq.pop_front() : 33'h1ffffffff);
  end
  initial
  begin
    {presetn, psel, penable, pwrite, jack, mclk, vclk, above, run_m, run_v} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 67;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) xfer(1'b0, regs[i], 9'h000, 1'b0);
    xfer(1'b1, 8'h20, 9'h1ff, 1'b1);
    xfer(1'b0, 8'h20, 9'h000, 1'b1);
    xfer(1'b1, `JMD_IDX_STATUS, 9'h1ff, 1'b0);
    xfer(1'b0, `JMD_IDX_STATUS, 9'h000, 1'b0);
    foreach (regs[i])
    begin
      v = 9'($random(seed));
      xfer(1'b1, regs[i], v, 1'b0);
      xfer(1'b0, regs[i], v, 1'b0);
      xfer(1'b1, regs[i], 9'h000, 1'b0);
    end
    $display("test registers done");
    xfer(1'b1, `JMD_IDX_PWR1, 9'h020, 1'b0);
    xfer(1'b1, `JMD_IDX_BIAS_CMP, 9'h003, 1'b0);
    repeat (2) @(posedge pclk);
    check("bias", {27'h0, mb, vs, thr, ce}, 33'h23);
    for (int c = 0; c < 8; c++)
    begin
      xfer(1'b1, `JMD_IDX_PIN_FN, 9'(c), 1'b0);
      repeat (2) @(posedge pclk);
      check("pulls", {31'h0, pu, pd}, {31'h0, c == 1, c == 2});
    end
    $display("test bias_and_pulls done");
    xfer(1'b1, `JMD_IDX_PWR3, 9'h1e0, 1'b0);
    xfer(1'b1, `JMD_IDX_OUT_CTL, 9'h040, 1'b0);
    jack <= 1'b1;
    run_m <= 1'b1;
    repeat (600) @(posedge pclk);
    check("early", {29'h0, hl, hr, sl, sr}, 33'h3);
    wait_drv(4'hc, 3000);
    xfer(1'b1, `JMD_IDX_OUT_CTL, 9'h060, 1'b0);
    wait_drv(4'h3, 4);
    run_m <= 1'b0;
    run_v <= 1'b1;
    xfer(1'b1, `JMD_IDX_CLK_SRC, 9'h020, 1'b0);
    jack <= 1'b0;
    wait_drv(4'hc, 3000);
    xfer(1'b1, `JMD_IDX_PWR3, 9'h0a0, 1'b0);
    wait_drv(4'h4, 4);
    xfer(1'b1, `JMD_IDX_OUT_CTL, 9'h000, 1'b0);
    wait_drv(4'h5, 4);
    run_v <= 1'b0;
    $display("test jack_switch done");
    base = irq_count;
    xfer(1'b1, `JMD_IDX_PIN_FN, 9'h108, 1'b0);
    xfer(1'b1, `JMD_IDX_IRQ_EN, 9'h002, 1'b0);
    above <= 1'b1;
    repeat (6) @(posedge pclk);
    check("irq", {31'h0, irq_oe, irq_o}, 33'h3);
    above <= 1'b0;
    repeat (6) @(posedge pclk);
    check("irq held", {31'h0, irq_oe, irq_o}, 33'h3);
    xfer(1'b1, `JMD_IDX_IRQ_EN, 9'h000, 1'b0);
    repeat (4) @(posedge pclk);
    check("irq clear", {31'h0, irq_oe, irq_o}, 33'h2);
    xfer(1'b1, `JMD_IDX_IRQ_POL, 9'h002, 1'b0);
    xfer(1'b1, `JMD_IDX_IRQ_EN, 9'h002, 1'b0);
    repeat (6) @(posedge pclk);
    check("irq count", 33'(irq_count - base), 33'h2);
    xfer(1'b1, `JMD_IDX_IRQ_EN, 9'h000, 1'b0);
    xfer(1'b1, `JMD_IDX_IRQ_POL, 9'h004, 1'b0);
    xfer(1'b1, `JMD_IDX_IRQ_EN, 9'h004, 1'b0);
    repeat (6) @(posedge pclk);
    check("jack irq", {31'h0, irq_oe, irq_o}, 33'h3);
    xfer(1'b0, `JMD_IDX_STATUS, 9'h018, 1'b0);
    xfer(1'b1, `JMD_IDX_IRQ_EN, 9'h000, 1'b0);
    xfer(1'b1, `JMD_IDX_IRQ_POL, 9'h000, 1'b0);
    xfer(1'b1, `JMD_IDX_IRQ_EN, 9'h004, 1'b0);
    repeat (6) @(posedge pclk);
    check("jack irq idle", {31'h0, irq_oe, irq_o}, 33'h2);
    xfer(1'b1, `JMD_IDX_PIN_FN, 9'h188, 1'b0);
    repeat (2) @(posedge pclk);
    check("irq low", {31'h0, irq_oe, irq_o}, 33'h3);
    xfer(1'b1, `JMD_IDX_PIN_FN, 9'h008, 1'b0);
    repeat (2) @(posedge pclk);
    check("irq drain idle", {31'h0, irq_oe, irq_o}, 33'h0);
    xfer(1'b1, `JMD_IDX_IRQ_POL, 9'h004, 1'b0);
    repeat (4) @(posedge pclk);
    check("irq drain", {31'h0, irq_oe, irq_o}, 33'h2);
    $display("test interrupts done");
    complete_run();
  end
endmodule
